// >>> rtl/code_mem_timing_pkg.sv
// Constants, types and carriers shared by the code memory timing block.
package code_mem_timing_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SRAM_ACCESS_NS = 2;
	localparam int unsigned PROG_TIME_US = 50;
	localparam int unsigned ERASE_TIME_MS = 20;
	localparam int unsigned PROG_CYCLES = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_CYCLES =
		(ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ABORT_CYCLES = 10;

	// ----------------------------------------------------------------
	// Cycle counts per phase
	// ----------------------------------------------------------------
	localparam logic [1:0] FETCH_SLOW_EXTRA = 2'h1;
	localparam logic [5:0] SRAM_DATA_CYC = 6'h01;
	localparam logic [5:0] SRAM_FLASH_DATA_CYC = 6'h03;
	localparam logic [2:0] SRAM_REFILL_CYC = 3'h2;
	localparam logic [1:0] FLASH_DECODE_CYC = 2'h1;
	localparam logic [2:0] FLASH_REFILL_CYC = 3'h4;
	localparam logic [4:0] DEAD_SINGLE_CYC = 5'h01;
	localparam logic [5:0] WORD_DATA_CYC = 6'h02;
	localparam logic [5:0] HALF_DATA_CYC = 6'h01;
	localparam logic [5:0] WORD_PROG_CNT = 6'h02;
	localparam logic [5:0] HALF_PROG_CNT = 6'h01;
	localparam logic [4:0] MULTI_MIN = 5'h02;
	localparam logic [4:0] MULTI_MAX = 5'h10;

	// ----------------------------------------------------------------
	// Divider field and register space
	// ----------------------------------------------------------------
	localparam int unsigned DIV_W = 3;
	localparam logic [DIV_W-1:0] DIV_FULL_SPEED = 3'h0;
	localparam logic [19:0] MMR_PAGE = 20'hF_FFFF;
	localparam int unsigned MMR_PAGE_LSB = 12;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {REG_SRAM = 2'h0, REG_FLASH = 2'h1, REG_MMR = 2'h2} region_e;
	typedef enum logic [1:0] {
		CLS_DP = 2'h0,
		CLS_LOAD = 2'h1,
		CLS_STORE = 2'h2,
		CLS_CTRL = 2'h3
	} class_e;
	typedef enum logic {SZ_HALF = 1'b0, SZ_WORD = 1'b1} size_e;
	typedef enum logic [1:0] {W8 = 2'h0, W16 = 2'h1, W32 = 2'h2} reg_width_e;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_FETCH = 9'h002,
		ST_DEAD = 9'h004,
		ST_DATA = 9'h008,
		ST_PROG = 9'h010,
		ST_DECODE = 9'h020,
		ST_REFILL = 9'h040,
		ST_ERASE = 9'h080,
		ST_ABORT = 9'h100
	} state_e;

	typedef struct packed {
		region_e code_region;
		logic compact;
		class_e cls;
		region_e data_region;
		size_e size;
		logic [4:0] count;
	} op_s;

	typedef struct packed {
		logic valid;
		logic write;
		size_e size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mmr_req_s;

endpackage : code_mem_timing_pkg

// >>> rtl/mmr_lane_adapter.sv
// Register-space decode and lane placement for core accesses.
`timescale 1ns/1ps
module mmr_lane_adapter
	import code_mem_timing_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Core side
	input mmr_req_s req,
	output logic hit,
	output logic [31:0] rdata_q,
	output logic err_q,
	// Peripheral side
	input reg_width_e per_width,
	input wire logic [31:0] per_rdata,
	output logic per_we,
	output logic [31:0] per_wdata
);

	logic half_on_wide;
	logic [31:0] rdata_d;
	logic err_d;

	// ----------------------------------------------------------------
	// Decode and write path
	// ----------------------------------------------------------------
	always_comb
	begin
		hit = req.valid && (req.addr[31:MMR_PAGE_LSB] == MMR_PAGE);
		half_on_wide = (req.size == SZ_HALF) && (per_width == W32);
		per_we = hit && req.write;
		per_wdata = req.wdata;
		if (half_on_wide)
		begin
			per_wdata = {16'h0000, req.wdata[15:0]};
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Narrow registers land in the low lanes; bits above their width read as zero.
	always_comb
	begin
		rdata_d = rdata_q;
		err_d = 1'b0;
		if (hit)
		begin
			err_d = half_on_wide;
			unique case (per_width)
				W8: rdata_d = {24'h00_0000, per_rdata[7:0]};
				W16: rdata_d = {16'h0000, per_rdata[15:0]};
				default: rdata_d = per_rdata;
			endcase
			if (req.size == SZ_HALF)
			begin
				rdata_d = {16'h0000, rdata_d[15:0]};
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

endmodule : mmr_lane_adapter

// >>> rtl/code_memory_access_timing.sv
// Wait-state sequencer for code memory fetch, data, program and erase timing.
`timescale 1ns/1ps
module code_memory_access_timing
	import code_mem_timing_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_CYCLES,
	parameter int unsigned ERASE_CYC = ERASE_CYCLES
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Configuration
	input wire logic [DIV_W-1:0] core_clock_divider,
	// Core instruction stream
	input wire logic op_valid,
	input op_s op,
	output logic op_ready,
	output logic mem_wait,
	output logic op_done_q,
	// Flash command and interrupt
	input wire logic flash_cmd_valid,
	input wire logic flash_cmd_erase,
	input wire logic enabled_irq,
	output logic flash_busy,
	output logic flash_done_q,
	output logic flash_aborted_q,
	// Register space access
	input mmr_req_s mmr_req,
	output logic mmr_hit,
	output logic [31:0] mmr_rdata_q,
	output logic mmr_err_q,
	input reg_width_e per_width,
	input wire logic [31:0] per_rdata,
	output logic per_we,
	output logic [31:0] per_wdata
);

	state_e st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic [1:0] fetch_q, fetch_d;
	logic [4:0] dead_q, dead_d;
	logic [5:0] data_q, data_d;
	logic [5:0] prog_q, prog_d;
	logic [1:0] dec_q, dec_d;
	logic [2:0] refill_q, refill_d;
	logic op_done_d;
	logic flash_done_d;
	logic flash_aborted_d;
	logic cmd_run_q, cmd_run_d;

	// ----------------------------------------------------------------
	// Phase ordering
	// ----------------------------------------------------------------
	// Phases run in a fixed order; a phase with nothing left is skipped.
	function automatic state_e pick(
		input logic [1:0] f,
		input logic [4:0] d,
		input logic [5:0] a,
		input logic [5:0] p,
		input logic [1:0] c,
		input logic [2:0] r
	);
		if (f != 2'h0)
			return ST_FETCH;
		else if (d != 5'h00)
			return ST_DEAD;
		else if (a != 6'h00)
			return ST_DATA;
		else if (p != 6'h00)
			return ST_PROG;
		else if (c != 2'h0)
			return ST_DECODE;
		else if (r != 3'h0)
			return ST_REFILL;
		else
			return ST_IDLE;
	endfunction : pick

	// ----------------------------------------------------------------
	// Handshake outputs
	// ----------------------------------------------------------------
	// Commands win over instructions in an idle cycle, so an SRAM-resident routine is
	// also held during a flash operation; the trade keeps one sequencer for all timing.
	assign op_ready = (st_q == ST_IDLE) && !flash_cmd_valid;
	assign mem_wait = (st_q != ST_IDLE);
	assign flash_busy = (st_q == ST_ERASE) || (st_q == ST_ABORT) || (cmd_run_q && st_q == ST_PROG);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		logic multi;
		logic flash_code;
		logic slow;
		multi = 1'b0;
		flash_code = 1'b0;
		slow = 1'b0;
		st_d = st_q;
		cnt_d = cnt_q;
		fetch_d = fetch_q;
		dead_d = dead_q;
		data_d = data_q;
		prog_d = prog_q;
		dec_d = dec_q;
		refill_d = refill_q;
		cmd_run_d = cmd_run_q;
		op_done_d = 1'b0;
		flash_done_d = 1'b0;
		flash_aborted_d = 1'b0;
		unique case (st_q)
			ST_IDLE:
			begin
				fetch_d = 2'h0;
				dead_d = 5'h00;
				data_d = 6'h00;
				prog_d = 6'h00;
				dec_d = 2'h0;
				refill_d = 3'h0;
				if (flash_cmd_valid)
				begin
					cmd_run_d = 1'b1;
					if (flash_cmd_erase)
					begin
						st_d = ST_ERASE;
						cnt_d = 32'(ERASE_CYC - 1);
					end
					else
					begin
						prog_d = HALF_PROG_CNT;
						st_d = ST_PROG;
					end
				end
				else if (op_valid)
				begin
					cmd_run_d = 1'b0;
					multi = (op.count >= MULTI_MIN) && (op.count <= MULTI_MAX);
					flash_code = (op.code_region == REG_FLASH);
					slow = (core_clock_divider == DIV_FULL_SPEED);
					// The accept cycle is the first fetch cycle, so SRAM fetches add nothing.
					if (flash_code && !op.compact && slow)
					begin
						fetch_d = FETCH_SLOW_EXTRA;
					end
					unique case (op.cls)
						CLS_LOAD, CLS_STORE:
						begin
							if (op.data_region != REG_FLASH)
							begin
								data_d = SRAM_DATA_CYC;
							end
							else if (!flash_code)
							begin
								data_d = (op.cls == CLS_LOAD) ? SRAM_FLASH_DATA_CYC : SRAM_DATA_CYC;
							end
							else
							begin
								dead_d = multi ? op.count : DEAD_SINGLE_CYC;
								if (op.cls == CLS_LOAD)
								begin
									data_d = multi ? {op.count, 1'b0} :
										((op.size == SZ_WORD) ? WORD_DATA_CYC : HALF_DATA_CYC);
								end
							end
							if (op.cls == CLS_STORE && op.data_region == REG_FLASH)
							begin
								prog_d = multi ? {op.count, 1'b0} :
									((op.size == SZ_WORD) ? WORD_PROG_CNT : HALF_PROG_CNT);
							end
						end
						CLS_CTRL:
						begin
							if (flash_code)
							begin
								dec_d = FLASH_DECODE_CYC;
								refill_d = slow ? FLASH_REFILL_CYC : 3'h0;
							end
							else
							begin
								refill_d = SRAM_REFILL_CYC;
							end
						end
						CLS_DP:
						begin
							dead_d = 5'h00;
						end
					endcase
					st_d = pick(fetch_d, dead_d, data_d, prog_d, dec_d, refill_d);
					op_done_d = (st_d == ST_IDLE);
				end
			end
			ST_FETCH:
			begin
				fetch_d = fetch_q - 2'h1;
				st_d = pick(fetch_d, dead_q, data_q, prog_q, dec_q, refill_q);
			end
			ST_DEAD:
			begin
				dead_d = dead_q - 5'h01;
				st_d = pick(2'h0, dead_d, data_q, prog_q, dec_q, refill_q);
			end
			ST_DATA:
			begin
				data_d = data_q - 6'h01;
				st_d = pick(2'h0, 5'h00, data_d, prog_q, dec_q, refill_q);
			end
			ST_PROG:
			begin
				if (enabled_irq)
				begin
					st_d = ST_ABORT;
					cnt_d = 32'(ABORT_CYCLES - 1);
				end
				else if (cnt_q == 32'h0000_0000)
				begin
					prog_d = prog_q - 6'h01;
					cnt_d = 32'(PROG_CYC - 1);
					st_d = pick(2'h0, 5'h00, 6'h00, prog_d, dec_q, refill_q);
				end
				else
				begin
					cnt_d = cnt_q - 32'h0000_0001;
				end
			end
			ST_DECODE:
			begin
				dec_d = dec_q - 2'h1;
				st_d = pick(2'h0, 5'h00, 6'h00, 6'h00, dec_d, refill_q);
			end
			ST_REFILL:
			begin
				refill_d = refill_q - 3'h1;
				st_d = pick(2'h0, 5'h00, 6'h00, 6'h00, 2'h0, refill_d);
			end
			ST_ERASE:
			begin
				if (enabled_irq)
				begin
					st_d = ST_ABORT;
					cnt_d = 32'(ABORT_CYCLES - 1);
				end
				else if (cnt_q == 32'h0000_0000)
				begin
					st_d = ST_IDLE;
				end
				else
				begin
					cnt_d = cnt_q - 32'h0000_0001;
				end
			end
			ST_ABORT:
			begin
				// The aborted command is not replayed here; the core reissues it.
				if (cnt_q == 32'h0000_0000)
				begin
					st_d = ST_IDLE;
					prog_d = 6'h00;
					flash_aborted_d = 1'b1;
				end
				else
				begin
					cnt_d = cnt_q - 32'h0000_0001;
				end
			end
			default:
			begin
				st_d = ST_IDLE;
			end
		endcase
		if (st_d == ST_PROG && st_q != ST_PROG)
		begin
			cnt_d = 32'(PROG_CYC - 1);
		end
		if (st_q != ST_IDLE && st_d == ST_IDLE && st_q != ST_ABORT)
		begin
			if (cmd_run_q)
			begin
				flash_done_d = 1'b1;
			end
			else
			begin
				op_done_d = 1'b1;
			end
		end
		if (st_q == ST_ABORT && st_d == ST_IDLE && !cmd_run_q)
		begin
			op_done_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 32'h0000_0000;
			fetch_q <= 2'h0;
			dead_q <= 5'h00;
			data_q <= 6'h00;
			prog_q <= 6'h00;
			dec_q <= 2'h0;
			refill_q <= 3'h0;
			cmd_run_q <= 1'b0;
			op_done_q <= 1'b0;
			flash_done_q <= 1'b0;
			flash_aborted_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			fetch_q <= fetch_d;
			dead_q <= dead_d;
			data_q <= data_d;
			prog_q <= prog_d;
			dec_q <= dec_d;
			refill_q <= refill_d;
			cmd_run_q <= cmd_run_d;
			op_done_q <= op_done_d;
			flash_done_q <= flash_done_d;
			flash_aborted_q <= flash_aborted_d;
		end
	end

	// ----------------------------------------------------------------
	// Register space
	// ----------------------------------------------------------------
	mmr_lane_adapter u_mmr (
		.ref_clk(ref_clk),
		.srst(srst),
		.req(mmr_req),
		.hit(mmr_hit),
		.rdata_q(mmr_rdata_q),
		.err_q(mmr_err_q),
		.per_width(per_width),
		.per_rdata(per_rdata),
		.per_we(per_we),
		.per_wdata(per_wdata)
	);

endmodule : code_memory_access_timing

// >>> tb/code_memory_access_timing_assertions.sv
// Checker of wait timing, flash abort and register lane behaviour.
`timescale 1ns/1ps
module code_memory_access_timing_assertions
	import code_mem_timing_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Core side
	input wire logic op_valid,
	input op_s op,
	input wire logic op_ready,
	input wire logic mem_wait,
	input wire logic op_done_q,
	// Flash side
	input wire logic enabled_irq,
	input wire logic flash_busy,
	input wire logic flash_aborted_q,
	// Register side
	input mmr_req_s mmr_req,
	input wire logic mmr_hit,
	input wire logic [31:0] mmr_rdata_q,
	input wire logic mmr_err_q,
	input reg_width_e per_width,
	input wire logic [31:0] per_rdata,
	input wire logic [31:0] per_wdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic sram_acc;
	logic half32;
	logic irq_seen_q;
	assign sram_acc = op_valid && op_ready && op.code_region == REG_SRAM;
	assign half32 = mmr_hit && mmr_req.size == SZ_HALF && per_width == W32;
	// Only the first busy cycle that sees the interrupt opens an abort window.
	always_ff @(posedge ref_clk)
		irq_seen_q <= !srst && flash_busy && enabled_irq;
	// --------
	// Assertions
	// --------
	AST_SRAM_NO_WAIT:
	assert property (sram_acc && op.cls == CLS_DP |=> op_done_q && !mem_wait)
		else $error("SRAM register op stalled");
	AST_SRAM_DATA_ONE:
	assert property (sram_acc && op.cls == CLS_LOAD && op.data_region == REG_SRAM
		|=> mem_wait ##1 (op_done_q && !mem_wait))
		else $error("SRAM data access not one cycle");
	AST_SRAM_REFILL:
	assert property (sram_acc && op.cls == CLS_CTRL |=> mem_wait [*2] ##1 (op_done_q && !mem_wait))
		else $error("SRAM branch refill not two cycles");
	AST_STALL_IN_FLASH_OP:
	assert property (flash_busy |-> mem_wait && !op_ready)
		else $error("Core not stalled during flash operation");
	AST_DONE_RELEASES_WAIT:
	assert property (op_done_q |-> !mem_wait)
		else $error("Done pulse while wait still held");
	AST_ABORT_TEN:
	assert property (flash_busy && enabled_irq && !irq_seen_q |=> flash_busy [*8] ##3 flash_aborted_q)
		else $error("Abort did not end after ten cycles");
	AST_REG_DECODE:
	assert property (mmr_hit == (mmr_req.valid && mmr_req.addr[31:12] == 20'hF_FFFF))
		else $error("Register space decode wrong");
	AST_HALF_WRITE_ZERO:
	assert property (half32 && mmr_req.write |-> per_wdata == {16'h0000, mmr_req.wdata[15:0]})
		else $error("Half write upper bits not zero");
	AST_HALF_READ_FLAG:
	assert property (half32 && !mmr_req.write |=> mmr_err_q
		&& ((mmr_rdata_q ^ $past(per_rdata)) & 32'h0000_FFFF) == 32'h0000_0000)
		else $error("Half read of wide register wrong");
	// --------
	// Coverage
	// --------
	COV_SRAM_BRANCH: cover property (sram_acc && op.cls == CLS_CTRL);
	COV_ABORT: cover property (flash_aborted_q);
	COV_HALF_WRITE: cover property (half32 && mmr_req.write);
endmodule : code_memory_access_timing_assertions

bind code_memory_access_timing code_memory_access_timing_assertions u_chk (
	.ref_clk(ref_clk), .srst(srst), .op_valid(op_valid), .op(op), .op_ready(op_ready),
	.mem_wait(mem_wait), .op_done_q(op_done_q), .enabled_irq(enabled_irq),
	.flash_busy(flash_busy), .flash_aborted_q(flash_aborted_q), .mmr_req(mmr_req),
	.mmr_hit(mmr_hit), .mmr_rdata_q(mmr_rdata_q), .mmr_err_q(mmr_err_q),
	.per_width(per_width), .per_rdata(per_rdata), .per_wdata(per_wdata)
);

// >>> tb/core_partner_model.sv
// Processor core model that issues instructions and flash commands.
`timescale 1ns/1ps
module core_partner_model
	import code_mem_timing_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Instruction stream
	output op_s op,
	output logic op_valid,
	input wire logic op_ready,
	input wire logic op_done_q,
	// Flash commands
	output logic flash_cmd_valid,
	output logic flash_cmd_erase,
	input wire logic enabled_irq,
	input wire logic flash_busy,
	input wire logic flash_done_q,
	input wire logic flash_aborted_q
);
	initial
	begin
		op = '0;
		op_valid = 1'b0;
		flash_cmd_valid = 1'b0;
		flash_cmd_erase = 1'b0;
	end

	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask : tick

	// Holds the instruction until taken, then counts inserted cycles.
	task automatic run_op(input op_s o, output int w);
		tick();
		op = o;
		op_valid = 1'b1;
		while (op_ready !== 1'b1) tick();
		tick();
		op_valid = 1'b0;
		w = 0;
		while (op_done_q !== 1'b1 && w < 5000)
		begin
			tick();
			w++;
		end
	endtask : run_op

	// An aborted command is sent again only after the interrupt is served.
	task automatic run_cmd(input logic erase, output int tries, output int n);
		tries = 0;
		do
		begin
			tick();
			while (enabled_irq !== 1'b0) tick();
			flash_cmd_erase = erase;
			flash_cmd_valid = 1'b1;
			tries++;
			while (flash_busy !== 1'b1) tick();
			flash_cmd_valid = 1'b0;
			n = 0;
			while (flash_done_q !== 1'b1 && flash_aborted_q !== 1'b1 && n < 9000)
			begin
				tick();
				n++;
			end
		end
		while (flash_aborted_q === 1'b1 && tries < 4);
	endtask : run_cmd
endmodule : core_partner_model

// >>> tb/tb_code_memory_access_timing.sv
// Self-checking bench for the code memory access timing block.
`timescale 1ns/1ps
module tb_code_memory_access_timing
	import code_mem_timing_pkg::*;
;
	localparam int PG = 20;
	localparam int ER = 50;
	typedef struct {op_s op; logic [2:0] div; int w;} row_s;
	logic ref_clk, srst, op_valid, op_ready, mem_wait, op_done_q, enabled_irq;
	logic flash_cmd_valid, flash_cmd_erase, flash_busy, flash_done_q, flash_aborted_q;
	logic mmr_hit, mmr_err_q, per_we;
	logic [DIV_W-1:0] core_clock_divider;
	logic [31:0] per_rdata, mmr_rdata_q, per_wdata;
	op_s op;
	mmr_req_s mmr_req;
	reg_width_e per_width;
	int err_total = 0;
	int num_checks = 0;
	int w, tries, n;
	row_s rows[$];

	code_memory_access_timing #(.PROG_CYC(PG), .ERASE_CYC(ER)) u_dut (
		.ref_clk(ref_clk), .srst(srst), .core_clock_divider(core_clock_divider),
		.op_valid(op_valid), .op(op), .op_ready(op_ready), .mem_wait(mem_wait),
		.op_done_q(op_done_q), .flash_cmd_valid(flash_cmd_valid),
		.flash_cmd_erase(flash_cmd_erase), .enabled_irq(enabled_irq), .flash_busy(flash_busy),
		.flash_done_q(flash_done_q), .flash_aborted_q(flash_aborted_q), .mmr_req(mmr_req),
		.mmr_hit(mmr_hit), .mmr_rdata_q(mmr_rdata_q), .mmr_err_q(mmr_err_q),
		.per_width(per_width), .per_rdata(per_rdata), .per_we(per_we), .per_wdata(per_wdata)
	);
	core_partner_model u_core (
		.ref_clk(ref_clk), .op(op), .op_valid(op_valid), .op_ready(op_ready),
		.op_done_q(op_done_q), .flash_cmd_valid(flash_cmd_valid),
		.flash_cmd_erase(flash_cmd_erase), .enabled_irq(enabled_irq), .flash_busy(flash_busy),
		.flash_done_q(flash_done_q), .flash_aborted_q(flash_aborted_q)
	);

	function automatic row_s mk(region_e c, logic k, class_e l, region_e d, size_e s,
		logic [4:0] cnt, logic [2:0] v, int x);
		row_s r;
		r.op = '{c, k, l, d, s, cnt};
		r.div = v;
		r.w = x;
		return r;
	endfunction : mk

	task automatic check_num(input int got, input int exp);
		num_checks++;
		if (got != exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check_num

	task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check_bits

	task automatic complete_run;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// One register access; read data is offered by the peripheral in the same cycle.
	task automatic mmr(input logic wr, input size_e sz, input logic [31:0] a,
		input reg_width_e wd, input logic [31:0] ex);
		logic h;
		h = a[31:12] == 20'hF_FFFF;
		@(posedge ref_clk);
		#1;
		mmr_req = '{1'b1, wr, sz, a, 32'hDEAD_BEEF};
		per_width = wd;
		per_rdata = 32'h1234_5678;
		#1;
		check_bits({30'h0, mmr_hit, per_we}, {30'h0, h, h & wr});
		if (wr)
			check_bits(per_wdata, ex);
		@(posedge ref_clk);
		#1;
		mmr_req.valid = 1'b0;
		check_bits({31'h0, mmr_err_q}, {31'h0, h && sz == SZ_HALF && wd == W32});
		if (h && !wr)
			check_bits(mmr_rdata_q & (sz == SZ_HALF ? 32'h0000_FFFF : 32'hFFFF_FFFF), ex);
	endtask : mmr

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		#100_000;
		err_total++;
		complete_run();
	end

	initial
	begin
		srst = 1'b1;
		core_clock_divider = '0;
		enabled_irq = 1'b0;
		mmr_req = '0;
		per_width = W8;
		per_rdata = '0;
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_DP, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 0));
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_LOAD, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 1));
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_LOAD, REG_FLASH, SZ_WORD, 5'h01, 3'h0, 3));
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_CTRL, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 2));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_DP, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 0));
		rows.push_back(mk(REG_FLASH, 1'b0, CLS_DP, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 1));
		rows.push_back(mk(REG_FLASH, 1'b0, CLS_DP, REG_SRAM, SZ_WORD, 5'h01, 3'h3, 0));
		rows.push_back(mk(REG_FLASH, 1'b0, CLS_LOAD, REG_FLASH, SZ_WORD, 5'h01, 3'h0, 4));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_LOAD, REG_FLASH, SZ_HALF, 5'h01, 3'h2, 2));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_STORE, REG_FLASH, SZ_HALF, 5'h01, 3'h1, 1 + PG));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_STORE, REG_FLASH, SZ_WORD, 5'h01, 3'h1, 1 + 2 * PG));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_CTRL, REG_SRAM, SZ_WORD, 5'h01, 3'h0, 5));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_LOAD, REG_FLASH, SZ_WORD, 5'h10, 3'h1, 48));
		rows.push_back(mk(REG_FLASH, 1'b1, CLS_STORE, REG_FLASH, SZ_WORD, 5'h02, 3'h1, 2 + 4 * PG));
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_STORE, REG_FLASH, SZ_HALF, 5'h01, 3'h0, 1 + PG));
		rows.push_back(mk(REG_FLASH, 1'b0, CLS_CTRL, REG_SRAM, SZ_WORD, 5'h01, 3'h1, 1));
		rows.push_back(mk(REG_SRAM, 1'b0, CLS_LOAD, REG_MMR, SZ_WORD, 5'h01, 3'h0, 1));
		repeat (8) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		check_bits({29'h0, mem_wait, op_done_q, flash_busy}, 32'h0000_0000);
		foreach (rows[i])
		begin
			core_clock_divider = rows[i].div;
			u_core.run_op(rows[i].op, w);
			check_num(w, rows[i].w);
		end
		u_core.run_cmd(1'b0, tries, n);
		check_num(n, PG);
		fork
			u_core.run_cmd(1'b1, tries, n);
			begin
				repeat (12) @(posedge ref_clk);
				#1;
				enabled_irq = 1'b1;
				@(posedge ref_clk);
				#1;
				enabled_irq = 1'b0;
			end
		join
		check_num(tries, 2);
		check_num(n, ER);
		mmr(1'b0, SZ_WORD, 32'hFFFF_0E20, W8, 32'h0000_0078);
		mmr(1'b0, SZ_WORD, 32'hFFFF_0500, W16, 32'h0000_5678);
		mmr(1'b0, SZ_WORD, 32'hFFFF_0404, W32, 32'h1234_5678);
		mmr(1'b0, SZ_HALF, 32'hFFFF_0404, W32, 32'h0000_5678);
		mmr(1'b1, SZ_HALF, 32'hFFFF_0404, W32, 32'h0000_BEEF);
		mmr(1'b1, SZ_WORD, 32'hFFFE_F000, W32, 32'hDEAD_BEEF);
		// Read data still holds the last hit, so a second reset must clear it.
		@(posedge ref_clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		check_bits({28'h0, mem_wait, op_done_q, flash_busy, mmr_err_q}, 32'h0000_0000);
		check_bits(mmr_rdata_q, 32'h0000_0000);
		core_clock_divider = 3'h0;
		u_core.run_op(rows[1].op, w);
		check_num(w, rows[1].w);
		complete_run();
	end
endmodule : tb_code_memory_access_timing
